// >>> dv/bridge_bank_asserts.sv
// assertion checker for the bridge bus number and i/o window bank
module bridge_bank_asserts #(
  parameter IO_ADDR_W = 16
) (
  // clock and reset
  input wire                 clk_in,
  input wire                 nrst_in,
  input wire                 ce_in,
  // configuration access
  input wire                 cfg_rd_en_in,
  input wire [5:0]           cfg_dw_addr_in,
  input wire [31:0]          cfg_rdata_out,
  input wire                 cfg_ack_out,
  input wire                 cfg_hit_out,
  // routing
  input wire                 cfg_route_valid_out,
  input wire                 cfg_route_type0_out,
  input wire                 cfg_route_type1_out,
  input wire                 io_req_in,
  input wire                 io_route_valid_out,
  input wire                 io_route_fwd_out,
  // tenure and window
  input wire                 tenure_active_in,
  input wire                 tenure_expired_out,
  input wire                 tenure_release_out,
  input wire [IO_ADDR_W-1:0] io_window_start_out,
  input wire [IO_ADDR_W-1:0] io_window_end_out,
  input wire                 io_window_open_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_rd(dw);
    ce_in && cfg_rd_en_in && cfg_dw_addr_in == dw;
  endsequence
  property p_upstream_zero;
    s_rd(6'h06) |=> cfg_rdata_out[7:0] == 8'h00;
  endproperty
  a_upstream_zero: assert property (p_upstream_zero)
    else $error("upstream bus number not zero");
  property p_tenure_rsvd;
    s_rd(6'h06) |=> cfg_rdata_out[26:24] == 3'h0;
  endproperty
  a_tenure_rsvd: assert property (p_tenure_rsvd)
    else $error("tenure reserved bits not zero");
  property p_window_rsvd;
    s_rd(6'h07) |=> cfg_rdata_out[31:16] == 16'h0000
      && cfg_rdata_out[11:8] == 4'h0 && cfg_rdata_out[3:0] == 4'h0;
  endproperty
  a_window_rsvd: assert property (p_window_rsvd)
    else $error("window reserved bits not zero");
  property p_unmapped;
    ce_in && cfg_rd_en_in && cfg_dw_addr_in[5:1] != 5'h03
      |=> cfg_ack_out && !cfg_hit_out && cfg_rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read answered wrongly");
  property p_start_fill;
    io_window_start_out[11:0] == 12'h000;
  endproperty
  a_start_fill: assert property (p_start_fill)
    else $error("window start low bits not zero");
  property p_end_fill;
    io_window_end_out != 16'h0000 |-> io_window_end_out[11:0] == 12'hFFF;
  endproperty
  a_end_fill: assert property (p_end_fill)
    else $error("window end low bits not all ones");
  property p_closed;
    io_route_fwd_out |-> io_route_valid_out && io_window_open_out;
  endproperty
  a_closed: assert property (p_closed)
    else $error("forward while window closed");
  property p_io_answer;
    ce_in && io_req_in |=> io_route_valid_out;
  endproperty
  a_io_answer: assert property (p_io_answer)
    else $error("io request not classified");
  property p_route_excl;
    cfg_route_type0_out || cfg_route_type1_out |-> cfg_route_valid_out
      && !(cfg_route_type0_out && cfg_route_type1_out);
  endproperty
  a_route_excl: assert property (p_route_excl)
    else $error("config route kinds overlap");
  property p_tenure_clear;
    ce_in && !tenure_active_in |=> !tenure_expired_out && !tenure_release_out;
  endproperty
  a_tenure_clear: assert property (p_tenure_clear)
    else $error("tenure flags stay without ownership");
endmodule

bind p2p_bridge_bus_io_window bridge_bank_asserts #(
  .IO_ADDR_W(IO_ADDR_W)) u_bridge_bank_asserts (
  .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
  .cfg_rd_en_in(cfg_rd_en_in), .cfg_dw_addr_in(cfg_dw_addr_in),
  .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
  .cfg_hit_out(cfg_hit_out), .cfg_route_valid_out(cfg_route_valid_out),
  .cfg_route_type0_out(cfg_route_type0_out),
  .cfg_route_type1_out(cfg_route_type1_out), .io_req_in(io_req_in),
  .io_route_valid_out(io_route_valid_out),
  .io_route_fwd_out(io_route_fwd_out), .tenure_active_in(tenure_active_in),
  .tenure_expired_out(tenure_expired_out),
  .tenure_release_out(tenure_release_out),
  .io_window_start_out(io_window_start_out),
  .io_window_end_out(io_window_end_out),
  .io_window_open_out(io_window_open_out));

// >>> dv/p2p_bridge_bus_io_window_bench.sv
// self-checking bench for the bridge bus number and i/o window bank
module p2p_bridge_bus_io_window_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        rd_en = 1'b0, wr_en = 1'b0, cyc_v = 1'b0, io_req = 1'b0;
  logic        t_start = 1'b0, t_act = 1'b0, other_req = 1'b0, ce = 1'b1;
  logic [5:0]  dw = 6'h00;
  logic [3:0]  be = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic [7:0]  bus = 8'h00, down_bus, high_bus;
  logic [15:0] addr = 16'h0000, w_start, w_end;
  logic        ack, hit, rv, t0, t1, iv, fwd, gnt, expd, rel, w_open;
  logic [15:0] io_a [4] = '{16'h2000, 16'h3FFF, 16'h4000, 16'h1FFF};
  logic        io_e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  int          bad_count = 0, compares = 0, cycles = 0, n;

  p2p_bridge_bus_io_window u_p2p_bridge_bus_io_window (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
    .cfg_rd_en_in(rd_en), .cfg_wr_en_in(wr_en), .cfg_dw_addr_in(dw),
    .cfg_be_in(be), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata),
    .cfg_ack_out(ack), .cfg_hit_out(hit), .cfg_cycle_valid_in(cyc_v),
    .cfg_cycle_bus_in(bus), .cfg_route_valid_out(rv),
    .cfg_route_type0_out(t0), .cfg_route_type1_out(t1),
    .io_req_in(io_req), .io_addr_in(addr), .io_route_valid_out(iv),
    .io_route_fwd_out(fwd), .tenure_start_in(t_start),
    .tenure_active_in(t_act), .gnt_in(gnt), .tenure_expired_out(expd),
    .tenure_release_out(rel), .downstream_bus_field_out(down_bus),
    .highest_bus_field_out(high_bus), .io_window_start_out(w_start),
    .io_window_end_out(w_end), .io_window_open_out(w_open));
  sec_bus_arbiter u_sec_bus_arbiter (.clk_in(clk_in), .nrst_in(nrst_in),
    .other_req_in(other_req), .gnt_out(gnt));

  always #25 clk_in = ~clk_in;
  // the whole run needs well under a thousand clocks
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(input logic rd, input logic [5:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge clk_in);
    rd_en <= rd;
    wr_en <= !rd;
    dw <= a;
    be <= b;
    wdata <= d;
    @(posedge clk_in);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    #1;
    q = rdata;
    chk("ack hit", {30'h0, ack, hit}, {30'h1, a[5:1] == 5'h03});
  endtask
  task automatic cls(input logic io, input logic [15:0] v,
                     input logic [1:0] e);
    @(posedge clk_in);
    io_req <= io;
    cyc_v <= !io;
    addr <= v;
    bus <= v[7:0];
    @(posedge clk_in);
    io_req <= 1'b0;
    cyc_v <= 1'b0;
    #1;
    if (io) chk("io route", {iv, fwd}, {1'b1, e[0]});
    else chk("cfg route", {rv, t0, t1}, {1'b1, e});
  endtask
  task automatic tenure(output int k);
    @(posedge clk_in);
    t_start <= 1'b1;
    t_act <= 1'b1;
    @(posedge clk_in);
    t_start <= 1'b0;
    k = 0;
    while (k < 20 && expd !== 1'b1) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask

  initial begin
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    cls(1, 16'h0000, 2'b00);
    cls(1, 16'hF000, 2'b00);
    acc(1, 6'h06, 4'hF, 32'h0);
    chk("dword 06h", q, 32'h0000_0000);
    acc(1, 6'h07, 4'hF, 32'h0);
    chk("dword 07h", q, 32'h0000_00F0);
    acc(0, 6'h06, 4'hF, 32'hFF03_01AB);
    acc(0, 6'h07, 4'h3, 32'hFFFF_3F2F);
    acc(1, 6'h06, 4'hF, 32'h0);
    chk("dword 06h", q, 32'hF803_0100);
    chk("tenure field", {24'h0, q[31:24]}, 32'h0000_00F8);
    acc(1, 6'h07, 4'hF, 32'h0);
    chk("dword 07h", q, 32'h0000_3020);
    chk("bus copies", {down_bus, high_bus}, 32'h0000_0103);
    chk("window", {w_start, w_end}, 32'h2000_3FFF);
    foreach (io_a[i]) cls(1, io_a[i], {1'b0, io_e[i]});
    for (int b = 0; b < 5; b++)
      cls(0, 16'(b), {b == 1, b == 2 || b == 3});
    // one device below: highest equals downstream
    acc(0, 6'h06, 4'h4, 32'h0001_0000);
    cls(0, 16'h0001, 2'b10);
    cls(0, 16'h0002, 2'b00);
    // clock enable low freezes the bank, so this write is lost
    @(posedge clk_in);
    ce <= 1'b0;
    wr_en <= 1'b1;
    dw <= 6'h06;
    be <= 4'h2;
    wdata <= 32'h0000_5500;
    @(posedge clk_in);
    ce <= 1'b1;
    wr_en <= 1'b0;
    #1;
    chk("frozen ack", {31'h0, ack}, 32'h0);
    acc(1, 6'h06, 4'hF, 32'h0);
    chk("frozen dword 06h", q, 32'hF801_0100);
    acc(0, 6'h07, 4'h3, 32'h0000_4050);
    repeat (2) @(posedge clk_in);
    chk("window open", {31'h0, w_open}, 32'h0);
    cls(1, 16'h4000, 2'b00);
    cls(1, 16'h5000, 2'b00);
    acc(1, 6'h08, 4'hF, 32'h0);
    chk("unmapped", q, 32'h0);
    acc(0, 6'h06, 4'h8, 32'h0800_0000);
    tenure(n);
    chk("tenure span", {31'h0, n >= 7 && n <= 9}, 32'h1);
    other_req <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("release", {31'h0, rel}, 32'h1);
    @(posedge clk_in);
    t_act <= 1'b0;
    other_req <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    chk("tenure flags", {expd, rel}, 32'h0);
    acc(0, 6'h06, 4'h8, 32'h0);
    tenure(n);
    chk("disabled timer", n, 32'd20);
    t_act <= 1'b0;
    stop_test();
  end
endmodule

// >>> dv/sec_bus_arbiter.sv
// secondary bus arbiter model that parks the grant on the bridge
module sec_bus_arbiter (
  // clock and reset
  input  wire clk_in,
  input  wire nrst_in,
  // competing agent and grant
  input  wire other_req_in,
  output reg  gnt_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // registered like a real arbiter, so the grant drops one clock late
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) gnt_out <= 1'b0;
    else gnt_out <= !other_req_in;
  end
endmodule

// >>> hdl/p2p_bridge_bus_io_window.v
// bus number, secondary tenure and i/o window bank of the internal bridge
`include "p2p_bridge_consts.vh"

// Function
// RL1 - upstream bus number reads zero always, writes do nothing
// RL2 - downstream bus number is eight bits, resets zero, software assigned
// RL3 - bus numbers select which configuration cycles go to the secondary side
// RL4 - highest bus number is eight bit read/write, resets zero
// RL5 - software sets highest equal to downstream when one device sits below
// RL6 - tenure field bits 7:3 read/write, reset zero, zero disables timer
// RL7 - tenure value limits bridge master tenure on the secondary bus
// RL8 - forward i/o only when base <= address <= limit
// RL9 - window start bits 7:4 give A[15:12], low bits reserved, reset F0h
// RL10 - base comparison fills address bits 11:0 with zeros
// RL11 - limit comparison fills address bits 11:0 with ones
// RL12 - window end bits 7:4 give A[15:12], low bits reserved, reset 00h
// RL13 - base above limit forwards no i/o access at all
// RL14 - reserved bits read zero and ignore writes
module p2p_bridge_bus_io_window #(
  parameter IO_ADDR_W = 16,
  parameter BUS_W     = 8
) (
  // clock, reset and clock enable
  input  wire                 clk_in,
  input  wire                 nrst_in,
  input  wire                 ce_in,
  // configuration space access, dword wide with byte enables
  input  wire                 cfg_rd_en_in,
  input  wire                 cfg_wr_en_in,
  input  wire [5:0]           cfg_dw_addr_in,
  input  wire [3:0]           cfg_be_in,
  input  wire [31:0]          cfg_wdata_in,
  output reg  [31:0]          cfg_rdata_out,
  output reg                  cfg_ack_out,
  output reg                  cfg_hit_out,
  // configuration cycle routing
  input  wire                 cfg_cycle_valid_in,
  input  wire [BUS_W-1:0]     cfg_cycle_bus_in,
  output reg                  cfg_route_valid_out,
  output reg                  cfg_route_type0_out,
  output reg                  cfg_route_type1_out,
  // processor i/o routing
  input  wire                 io_req_in,
  input  wire [IO_ADDR_W-1:0] io_addr_in,
  output reg                  io_route_valid_out,
  output reg                  io_route_fwd_out,
  // secondary bus master tenure
  input  wire                 tenure_start_in,
  input  wire                 tenure_active_in,
  input  wire                 gnt_in,
  output wire                 tenure_expired_out,
  output wire                 tenure_release_out,
  // current settings for the rest of the bridge
  output reg  [BUS_W-1:0]     downstream_bus_field_out,
  output reg  [BUS_W-1:0]     highest_bus_field_out,
  output reg  [IO_ADDR_W-1:0] io_window_start_out,
  output reg  [IO_ADDR_W-1:0] io_window_end_out,
  output reg                  io_window_open_out
);

  // stored fields
  reg  [7:0] downstream_bus_field;
  reg  [7:0] highest_bus_field;
  reg  [4:0] tenure_count_field;
  reg  [3:0] io_window_start_field;
  reg  [3:0] io_window_end_field;

  // assembled register images
  wire [7:0] upstream_bus_field;
  wire [7:0] secondary_latency_timer;
  wire [7:0] io_window_lower;
  wire [7:0] io_window_upper;

  // decode helpers
  wire                 dw_bus_sel;
  wire                 dw_io_sel;
  wire [IO_ADDR_W-1:0] next_window_start;
  wire [IO_ADDR_W-1:0] next_window_end;
  wire                 next_window_open;
  wire                 io_above_start;
  wire                 io_below_end;
  wire                 io_upper_zero;
  wire                 next_io_fwd;
  wire                 next_cfg_type0;
  wire                 next_cfg_type1;
  reg  [31:0]          next_rdata;

  // reset images, so the field slices are cut on purpose
  localparam [7:0] TENURE_RESET_IMAGE = `RST_SEC_LAT_TIMER;
  localparam [7:0] START_RESET_IMAGE  = `RST_IO_LOWER;
  localparam [7:0] END_RESET_IMAGE    = `RST_IO_UPPER;

  assign dw_bus_sel = (cfg_dw_addr_in == `DW_BUS_NUMBERS);
  assign dw_io_sel  = (cfg_dw_addr_in == `DW_IO_WINDOW);

  // hardwired, the internal bridge always hangs off bus zero
  assign upstream_bus_field = `RST_PRIMARY_BUS; // RL1

  assign secondary_latency_timer = {tenure_count_field, 3'h0}; // RL6 RL14
  assign io_window_lower         = {io_window_start_field, 4'h0}; // RL9 RL14
  assign io_window_upper         = {io_window_end_field, 4'h0}; // RL12 RL14

  // register writes, byte lane per offset
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      downstream_bus_field  <= `RST_SECONDARY_BUS; // RL2
      highest_bus_field     <= `RST_SUBORDINATE_BUS; // RL4
      tenure_count_field    <=
        TENURE_RESET_IMAGE[`TENURE_MSB:`TENURE_LSB]; // RL6
      io_window_start_field <=
        START_RESET_IMAGE[`IO_FIELD_MSB:`IO_FIELD_LSB]; // RL9
      io_window_end_field   <=
        END_RESET_IMAGE[`IO_FIELD_MSB:`IO_FIELD_LSB]; // RL12
    end else if (ce_in && cfg_wr_en_in) begin
      // lane 0 of the bus dword is the read-only upstream number
      if (dw_bus_sel && cfg_be_in[1]) begin
        downstream_bus_field <= cfg_wdata_in[15:8]; // RL2
      end
      if (dw_bus_sel && cfg_be_in[2]) begin
        highest_bus_field <= cfg_wdata_in[23:16]; // RL4
      end
      if (dw_bus_sel && cfg_be_in[3]) begin
        // low three bits are dropped
        tenure_count_field <= cfg_wdata_in[24+`TENURE_MSB:24+`TENURE_LSB]; // RL6
      end
      if (dw_io_sel && cfg_be_in[0]) begin
        io_window_start_field <= cfg_wdata_in[`IO_FIELD_MSB:`IO_FIELD_LSB]; // RL9
      end
      if (dw_io_sel && cfg_be_in[1]) begin
        io_window_end_field <= cfg_wdata_in[8+`IO_FIELD_MSB:8+`IO_FIELD_LSB]; // RL12
      end
    end
  end

  // read mux, lanes outside this bank read zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (dw_bus_sel) begin
      next_rdata = {secondary_latency_timer, highest_bus_field,
                    downstream_bus_field, upstream_bus_field}; // RL1
    end else if (dw_io_sel) begin
      // upper half belongs to the status register, not held here
      next_rdata = {16'h0000, io_window_upper, io_window_lower}; // RL14
    end
  end

  // configuration access answer one clock after the request
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_rdata_out <= 32'h0000_0000;
      cfg_ack_out   <= 1'b0;
      cfg_hit_out   <= 1'b0;
    end else if (ce_in) begin
      cfg_ack_out <= cfg_rd_en_in | cfg_wr_en_in;
      cfg_hit_out <= (cfg_rd_en_in | cfg_wr_en_in) & (dw_bus_sel | dw_io_sel);
      if (cfg_rd_en_in) begin
        cfg_rdata_out <= next_rdata;
      end else begin
        cfg_rdata_out <= 32'h0000_0000;
      end
    end
  end

  // window bounds widened to full i/o addresses
  assign next_window_start = {{(IO_ADDR_W-16){1'b0}},
                              io_window_start_field, `IO_BASE_FILL}; // RL10
  assign next_window_end   = {{(IO_ADDR_W-16){1'b0}},
                              io_window_end_field, `IO_LIMIT_FILL}; // RL11
  // a window with start above end is closed, as after reset
  assign next_window_open  = (io_window_start_field <= io_window_end_field); // RL13

  // only the 64 KB i/o space can ever be forwarded
  assign io_upper_zero  = (io_addr_in >> 16) == {IO_ADDR_W{1'b0}};
  assign io_above_start = (io_addr_in >= next_window_start); // RL8
  assign io_below_end   = (io_addr_in <= next_window_end); // RL8
  assign next_io_fwd    = io_upper_zero & io_above_start & io_below_end &
                          next_window_open; // RL8 RL13

  // i/o routing decision, registered one clock after the request
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      io_route_valid_out <= 1'b0;
      io_route_fwd_out   <= 1'b0;
    end else if (ce_in) begin
      io_route_valid_out <= io_req_in;
      io_route_fwd_out   <= io_req_in & next_io_fwd; // RL8
    end
  end

  // configuration cycle routing on the programmed bus range
  // the range test relies on software keeping highest >= downstream
  assign next_cfg_type0 = (cfg_cycle_bus_in == downstream_bus_field); // RL3
  assign next_cfg_type1 = (cfg_cycle_bus_in > downstream_bus_field) &&
                          (cfg_cycle_bus_in <= highest_bus_field); // RL3 RL5

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_route_valid_out <= 1'b0;
      cfg_route_type0_out <= 1'b0;
      cfg_route_type1_out <= 1'b0;
    end else if (ce_in) begin
      cfg_route_valid_out <= cfg_cycle_valid_in;
      cfg_route_type0_out <= cfg_cycle_valid_in & next_cfg_type0; // RL3
      cfg_route_type1_out <= cfg_cycle_valid_in & next_cfg_type1; // RL3
    end
  end

  // settings mirrored to the rest of the bridge
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      downstream_bus_field_out <= `RST_SECONDARY_BUS;
      highest_bus_field_out    <= `RST_SUBORDINATE_BUS;
      io_window_start_out      <= {IO_ADDR_W{1'b0}};
      io_window_end_out        <= {IO_ADDR_W{1'b0}};
      io_window_open_out       <= 1'b0;
    end else if (ce_in) begin
      downstream_bus_field_out <= downstream_bus_field;
      highest_bus_field_out    <= highest_bus_field;
      io_window_start_out      <= next_window_start;
      io_window_end_out        <= next_window_end;
      io_window_open_out       <= next_window_open; // RL13
    end
  end

  // tenure limit on the secondary bus
  tenure_timer #(
    .FIELD_W (5),
    .COUNT_W (8)
  ) u_tenure_timer (
    .clk_in                (clk_in),
    .nrst_in               (nrst_in),
    .ce_in                 (ce_in),
    .tenure_count_field_in (tenure_count_field),
    .tenure_start_in       (tenure_start_in),
    .tenure_active_in      (tenure_active_in),
    .gnt_in                (gnt_in),
    .tenure_expired_out    (tenure_expired_out),
    .tenure_release_out    (tenure_release_out)
  ); // RL7

endmodule

// >>> hdl/p2p_bridge_consts.vh
// offsets, field positions, reset values and timing counts of the bridge bank
`ifndef P2P_BRIDGE_CONSTS_VH
`define P2P_BRIDGE_CONSTS_VH

// byte offsets in configuration space
`define OFS_PRIMARY_BUS     8'h18
`define OFS_SECONDARY_BUS   8'h19
`define OFS_SUBORDINATE_BUS 8'h1A
`define OFS_SEC_LAT_TIMER   8'h1B
`define OFS_IO_LOWER        8'h1C
`define OFS_IO_UPPER        8'h1D

// dword indices holding the bank
`define DW_BUS_NUMBERS      6'h06
`define DW_IO_WINDOW        6'h07

// reset values
`define RST_PRIMARY_BUS     8'h00
`define RST_SECONDARY_BUS   8'h00
`define RST_SUBORDINATE_BUS 8'h00
`define RST_SEC_LAT_TIMER   8'h00
`define RST_IO_LOWER        8'hF0
`define RST_IO_UPPER        8'h00

// field positions
`define TENURE_MSB          7
`define TENURE_LSB          3
`define IO_FIELD_MSB        7
`define IO_FIELD_LSB        4

// decode fill for the low address bits of the window
`define IO_BASE_FILL        12'h000
`define IO_LIMIT_FILL       12'hFFF

// tenure count granularity as log2 of clocks per field step (3 gives eight)
`define TENURE_STEP_BITS    3

`endif

// >>> hdl/tenure_timer.v
// master tenure timer for the secondary bus
`include "p2p_bridge_consts.vh"

module tenure_timer #(
  parameter FIELD_W = 5,
  parameter COUNT_W = 8
) (
  // clock and reset
  input  wire               clk_in,
  input  wire               nrst_in,
  input  wire               ce_in,
  // programmed value
  input  wire [FIELD_W-1:0] tenure_count_field_in,
  // secondary bus master status
  input  wire               tenure_start_in,
  input  wire               tenure_active_in,
  input  wire               gnt_in,
  // results
  output reg                tenure_expired_out,
  output reg                tenure_release_out
);

  reg  [COUNT_W-1:0] count;
  reg                enabled;
  wire [COUNT_W-1:0] load_value;

  // field counts in steps of eight clocks
  assign load_value = {tenure_count_field_in, {`TENURE_STEP_BITS{1'b0}}};

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count              <= {COUNT_W{1'b0}};
      enabled            <= 1'b0;
      tenure_expired_out <= 1'b0;
      tenure_release_out <= 1'b0;
    end else if (ce_in) begin
      if (tenure_start_in) begin
        // zero field disables the limit altogether
        count              <= load_value;
        enabled            <= (tenure_count_field_in != {FIELD_W{1'b0}}); // RL6
        tenure_expired_out <= 1'b0;
        tenure_release_out <= 1'b0;
      end else if (!tenure_active_in) begin
        enabled            <= 1'b0;
        tenure_expired_out <= 1'b0;
        tenure_release_out <= 1'b0;
      end else if (enabled) begin
        if (count != {COUNT_W{1'b0}}) begin
          count <= count - {{(COUNT_W-1){1'b0}}, 1'b1}; // RL7
        end
        if (count <= {{(COUNT_W-1){1'b0}}, 1'b1}) begin
          tenure_expired_out <= 1'b1; // RL7
        end
        // still granted means the master may keep the bus
        tenure_release_out <= tenure_expired_out & ~gnt_in; // RL7
      end
    end
  end

endmodule
